// File: pkg/rbc_pkg.sv
// constants for the binary-capable real-time clock block
package rbc_pkg;
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned SUBTICK_PERIOD_NS = 3906250;
  localparam int unsigned TICK_CYCLES = SUBTICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int unsigned PRE_W = 17;
  localparam int unsigned CAP_SETS = 3;
  localparam int unsigned NUM_BYTES = 4;
  localparam int unsigned NUM_EVT = 5;
  // byte addresses of single registers
  localparam logic [7:0] ADR_CTRL_ONE = 8'h00;
  localparam logic [7:0] ADR_CTRL_TWO = 8'h04;
  localparam logic [7:0] ADR_CTRL_THREE = 8'h08;
  localparam logic [7:0] ADR_STATUS = 8'h0C;
  localparam logic [7:0] ADR_MASK = 8'h10;
  localparam logic [7:0] ADR_CAL_NOW = 8'h14;
  // 16-byte pages holding four byte registers each
  localparam logic [3:0] PG_CNT = 4'h2;
  localparam logic [3:0] PG_ALM = 4'h3;
  localparam logic [3:0] PG_AEN = 4'h4;
  localparam logic [3:0] PG_CAP0 = 4'h5;
  localparam logic [3:0] PG_CAP2 = 4'h7;
  localparam logic [1:0] CAP_PG_BASE = 2'h1;
  // control field positions and reset values
  localparam int unsigned CLKSEL_BIT = 0;
  localparam int unsigned RATE_LSB = 4;
  localparam int unsigned MODE_BIT = 0;
  localparam logic [3:0] RATE_RST = 4'h0;
  localparam logic [2:0] DRIVE_RST = 3'h0;
  localparam logic [3:0] RATE_MIN = 4'h6;
  localparam logic [8:0] FRAC_ONES = 9'h1FF;
  // status bit positions
  localparam int unsigned ST_ALM = 0;
  localparam int unsigned ST_PRD = 1;
  localparam int unsigned ST_CAP = 2;
  // sub-second counter taps
  localparam logic [7:0] SUB_MAX = 8'hFF;
  localparam int unsigned BIT_1HZ = 7;
  localparam int unsigned BIT_64HZ = 1;
  // calendar limits
  localparam logic [5:0] SEC_MAX = 6'h3B;
  localparam logic [5:0] MIN_MAX = 6'h3B;
  localparam logic [4:0] HOUR_MAX = 5'h17;
  localparam logic [4:0] DATE_MIN = 5'h01;
  localparam logic [4:0] DATE_MAX = 5'h1F;
  localparam logic [3:0] MON_MIN = 4'h1;
  localparam logic [3:0] MON_MAX = 4'hC;
endpackage

// File: rtl/rbc_rtc.sv
// real-time clock with binary count, alarm, periodic irq and time capture
// Functional notes
// - rate code 6..15 gives 1/256 s to 2 s
// - alarm and periodic irq raise wake-up
// - edge on event pin captures time
// - calendar mode captures month, date, hour, minute, second
// - binary mode captures full 32-bit count
// - three capture sets of four bytes
// - binary count seen as four bytes
// - per byte alarm compare and enable registers
// - mode bit selects calendar or binary counting
// - select bit picks clock output frequency
// - 3-bit field drives oscillator drive lines
// - alarm in binary mode only, when all enabled bits match
// - binary mode counts seconds, plain 32 bits
// - clock output 1 Hz or 64 Hz
//
// Added by the designer: the Wishbone interface to the registers and the address map.
`timescale 1ns/1ns
module rbc_rtc #(
  parameter int unsigned TICK_DIV = rbc_pkg::TICK_CYCLES // clocks per 1/256 s
) (
  input wire logic clk_i, // system clock
  input wire logic rst_i, // sync reset, high
  input wire logic wb_cyc_i, // bus cycle
  input wire logic wb_stb_i, // strobe
  input wire logic wb_we_i, // write
  input wire logic [7:0] wb_adr_i, // byte address
  input wire logic [3:0] wb_sel_i, // byte lanes
  input wire logic [31:0] wb_dat_i, // write data
  output logic [31:0] wb_dat_o, // read data
  output logic wb_ack_o, // acknowledge
  input wire logic [2:0] capture_evt_i, // capture event pins
  output logic irq_o, // level interrupt
  output logic wakeup_o, // standby wake request
  output logic clock_out_pin_o, // 1 Hz / 64 Hz
  output logic [2:0] subosc_drive_level_o // oscillator drive
);
  logic req, wr, sub_tick, tick_d, sec_inc, sec_d, clksel, mode, prd_fire, alm_fire;
  logic [3:0] page, cnt_we, alm_we, aen_we, rate, rate_w, cal_mon;
  logic [1:0] bsel, capy;
  logic [rbc_pkg::PRE_W-1:0] pre;
  logic [7:0] sub;
  logic [31:0] bin_cnt, next_bin_cnt, alarm, alarm_en, cal_word, next_rdat;
  logic [5:0] cal_sec, cal_min;
  logic [4:0] cal_hr, cal_date;
  logic [2:0] drive, evt_q, cap_edge;
  logic [8:0] pmask, frac;
  logic [31:0] cap [rbc_pkg::CAP_SETS];
  logic [rbc_pkg::NUM_EVT-1:0] stat, mask, stat_clr, ev;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // bus decode; writes land on the edge where the master sees ack
  assign req = wb_cyc_i & wb_stb_i;
  assign wr = req & wb_we_i & wb_ack_o & wb_sel_i[0];
  assign page = wb_adr_i[7:4];
  assign bsel = wb_adr_i[3:2];
  assign capy = 2'(wb_adr_i[5:4] - rbc_pkg::CAP_PG_BASE);
  assign cnt_we = (wr && page == rbc_pkg::PG_CNT) ? (4'h1 << bsel) : 4'h0;
  assign alm_we = (wr && page == rbc_pkg::PG_ALM) ? (4'h1 << bsel) : 4'h0;
  assign aen_we = (wr && page == rbc_pkg::PG_AEN) ? (4'h1 << bsel) : 4'h0;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= req & ~wb_ack_o;
    end
  end

  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held more than one cycle");

  // 1/256 s tick from the system clock
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pre <= '0;
      sub_tick <= 1'b0;
    end else if (pre == rbc_pkg::PRE_W'(TICK_DIV - 1)) begin
      pre <= '0;
      sub_tick <= 1'b1;
    end else begin
      pre <= pre + 1'b1;
      sub_tick <= 1'b0;
    end
  end

  assign sec_inc = sub_tick && sub == rbc_pkg::SUB_MAX;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sub <= '0;
      tick_d <= 1'b0;
      sec_d <= 1'b0;
    end else begin
      if (sub_tick) begin
        sub <= sub + 1'b1;
      end
      tick_d <= sub_tick;
      sec_d <= sec_inc;
    end
  end

  // binary seconds; a byte write beats the increment for that byte
  always_comb begin
    next_bin_cnt = bin_cnt;
    if (mode && sec_inc) begin
      next_bin_cnt = bin_cnt + 1'b1;
    end
    for (int n = 0; n < rbc_pkg::NUM_BYTES; n++) begin
      if (cnt_we[n]) begin
        next_bin_cnt[n*8 +: 8] = wb_dat_i[7:0];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bin_cnt <= '0;
    end else begin
      bin_cnt <= next_bin_cnt;
    end
  end

  a_bin_increment: assert property (mode && sec_inc && cnt_we == 4'h0 |=> bin_cnt == $past(bin_cnt) + 32'h1)
    else $error("binary count did not step by one");

  // reduced calendar: 31-day months, 24-hour, binary fields
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cal_sec <= '0;
      cal_min <= '0;
      cal_hr <= '0;
      cal_date <= rbc_pkg::DATE_MIN;
      cal_mon <= rbc_pkg::MON_MIN;
    end else if (!mode && sec_inc) begin
      if (cal_sec != rbc_pkg::SEC_MAX) begin
        cal_sec <= cal_sec + 1'b1;
      end else begin
        cal_sec <= '0;
        if (cal_min != rbc_pkg::MIN_MAX) begin
          cal_min <= cal_min + 1'b1;
        end else begin
          cal_min <= '0;
          if (cal_hr != rbc_pkg::HOUR_MAX) begin
            cal_hr <= cal_hr + 1'b1;
          end else begin
            cal_hr <= '0;
            if (cal_date != rbc_pkg::DATE_MAX) begin
              cal_date <= cal_date + 1'b1;
            end else begin
              cal_date <= rbc_pkg::DATE_MIN;
              cal_mon <= (cal_mon == rbc_pkg::MON_MAX) ? rbc_pkg::MON_MIN : cal_mon + 1'b1;
            end
          end
        end
      end
    end
  end

  assign cal_word = {6'h0, cal_mon, cal_date, cal_hr, cal_min, cal_sec};

  // control registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      clksel <= 1'b0;
      rate <= rbc_pkg::RATE_RST;
      mode <= 1'b0;
      drive <= rbc_pkg::DRIVE_RST;
    end else if (wr) begin
      if (wb_adr_i[7:2] == rbc_pkg::ADR_CTRL_ONE[7:2]) begin
        clksel <= wb_dat_i[rbc_pkg::CLKSEL_BIT];
        rate <= wb_dat_i[rbc_pkg::RATE_LSB +: 4];
      end
      if (wb_adr_i[7:2] == rbc_pkg::ADR_CTRL_TWO[7:2]) begin
        mode <= wb_dat_i[rbc_pkg::MODE_BIT];
      end
      if (wb_adr_i[7:2] == rbc_pkg::ADR_CTRL_THREE[7:2]) begin
        drive <= wb_dat_i[2:0];
      end
    end
  end

  // alarm compare and enable bytes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      alarm <= '0;
      alarm_en <= '0;
    end else begin
      for (int n = 0; n < rbc_pkg::NUM_BYTES; n++) begin
        if (alm_we[n]) begin
          alarm[n*8 +: 8] <= wb_dat_i[7:0];
        end
        if (aen_we[n]) begin
          alarm_en[n*8 +: 8] <= wb_dat_i[7:0];
        end
      end
    end
  end

  // checked once per second, after the count has moved
  assign alm_fire = sec_d && mode && (((bin_cnt ^ alarm) & alarm_en) == '0);

  a_alarm_match: assert property (sec_d && mode && ((bin_cnt ^ alarm) & alarm_en) == '0 |=> stat[rbc_pkg::ST_ALM])
    else $error("alarm match did not set status");

  // periodic: fire when the low (code-6) bits of seconds.fraction are zero
  // codes below 6 are not legal; they simply never fire
  assign rate_w = rate - rbc_pkg::RATE_MIN;
  assign pmask = ~(rbc_pkg::FRAC_ONES << rate_w);
  assign frac = {(mode ? bin_cnt[0] : cal_sec[0]), sub};
  assign prd_fire = tick_d && rate >= rbc_pkg::RATE_MIN && (frac & pmask) == '0;

  a_period_one_sec: assert property (tick_d && rate == 4'hE && sub == 8'h00 |=> stat[rbc_pkg::ST_PRD])
    else $error("1 s periodic event missing");
  a_period_quarter: assert property (tick_d && rate == 4'hC && sub[5:0] != 6'h00 && !stat[rbc_pkg::ST_PRD]
    |=> !stat[rbc_pkg::ST_PRD])
    else $error("1/4 s periodic event off its slot");

  // time capture, one set per event pin
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      evt_q <= '0;
    end else begin
      evt_q <= capture_evt_i;
    end
  end

  for (genvar g = 0; g < rbc_pkg::CAP_SETS; g++) begin : g_cap
    assign cap_edge[g] = capture_evt_i[g] & ~evt_q[g];
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        cap[g] <= '0;
      end else if (cap_edge[g]) begin
        cap[g] <= mode ? bin_cnt : cal_word;
      end
    end
  end

  a_cap_binary: assert property (mode && cap_edge[0] |=> cap[0] == $past(bin_cnt))
    else $error("binary capture wrong");
  a_cap_calendar: assert property (!mode && cap_edge[2] |=> cap[2][5:0] == $past(cal_sec)
    && cap[2][25:22] == $past(cal_mon))
    else $error("calendar capture wrong");
  a_cap_hold: assert property (!cap_edge[1] |=> $stable(cap[1]))
    else $error("capture changed without edge");

  // sticky status, write one to clear; a new event wins over the clear
  assign ev = {cap_edge, prd_fire, alm_fire};
  assign stat_clr = (wr && wb_adr_i[7:2] == rbc_pkg::ADR_STATUS[7:2]) ? wb_dat_i[rbc_pkg::NUM_EVT-1:0] : '0;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stat <= '0;
      mask <= '0;
    end else begin
      stat <= (stat & ~stat_clr) | ev;
      if (wr && wb_adr_i[7:2] == rbc_pkg::ADR_MASK[7:2]) begin
        mask <= wb_dat_i[rbc_pkg::NUM_EVT-1:0];
      end
    end
  end

  // outputs, all registered
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
      wakeup_o <= 1'b0;
      clock_out_pin_o <= 1'b0;
      subosc_drive_level_o <= rbc_pkg::DRIVE_RST;
    end else begin
      irq_o <= |(stat & mask);
      wakeup_o <= |(stat[rbc_pkg::ST_PRD:rbc_pkg::ST_ALM] & mask[rbc_pkg::ST_PRD:rbc_pkg::ST_ALM]);
      clock_out_pin_o <= clksel ? sub[rbc_pkg::BIT_64HZ] : sub[rbc_pkg::BIT_1HZ];
      subosc_drive_level_o <= drive;
    end
  end

  a_wake_alarm: assert property (stat[rbc_pkg::ST_ALM] && mask[rbc_pkg::ST_ALM] |=> wakeup_o)
    else $error("alarm gave no wake request");
  a_clkout_one_hz: assert property (!clksel |=> clock_out_pin_o == $past(sub[7]))
    else $error("1 Hz output wrong");
  a_drive_follow: assert property (##1 subosc_drive_level_o == $past(drive))
    else $error("drive level not forwarded");

  // read mux; unmapped addresses read zero
  always_comb begin
    next_rdat = '0;
    if (page == rbc_pkg::PG_CNT) begin
      next_rdat[7:0] = bin_cnt[bsel*8 +: 8];
    end else if (page == rbc_pkg::PG_ALM) begin
      next_rdat[7:0] = alarm[bsel*8 +: 8];
    end else if (page == rbc_pkg::PG_AEN) begin
      next_rdat[7:0] = alarm_en[bsel*8 +: 8];
    end else if (page >= rbc_pkg::PG_CAP0 && page <= rbc_pkg::PG_CAP2) begin
      next_rdat[7:0] = cap[capy][bsel*8 +: 8];
    end else begin
      unique case (wb_adr_i[7:2])
        rbc_pkg::ADR_CTRL_ONE[7:2]: begin
          next_rdat[rbc_pkg::RATE_LSB +: 4] = rate;
          next_rdat[rbc_pkg::CLKSEL_BIT] = clksel;
        end
        rbc_pkg::ADR_CTRL_TWO[7:2]: next_rdat[rbc_pkg::MODE_BIT] = mode;
        rbc_pkg::ADR_CTRL_THREE[7:2]: next_rdat[2:0] = drive;
        rbc_pkg::ADR_STATUS[7:2]: next_rdat[rbc_pkg::NUM_EVT-1:0] = stat;
        rbc_pkg::ADR_MASK[7:2]: next_rdat[rbc_pkg::NUM_EVT-1:0] = mask;
        rbc_pkg::ADR_CAL_NOW[7:2]: next_rdat = cal_word;
        default: next_rdat = '0;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= '0;
    end else if (req && !wb_ack_o) begin
      wb_dat_o <= next_rdat;
    end
  end
endmodule // rbc_rtc

// File: verification/rbc_rtc_tb.sv
// self-checking bench for the binary-capable real-time clock
`timescale 1ns/1ns
module rbc_rtc_tb;
  localparam int unsigned TD = 8; // short tick: one second is 2048 clocks
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic req = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] dw = 32'h0;
  logic [2:0] evt = 3'h0;
  logic [31:0] dr, rv, cnt;
  logic ack, irq, wake, cko;
  logic [2:0] drv;
  int miscompares = 0;
  int tests_run = 0;
  int k;
  time t1;
  always #25 clk_i = ~clk_i;
  // cyc and stb always move together in classic single cycles
  rbc_rtc #(.TICK_DIV(TD)) dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(req), .wb_stb_i(req), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dw), .wb_dat_o(dr), .wb_ack_o(ack), .capture_evt_i(evt),
    .irq_o(irq), .wakeup_o(wake), .clock_out_pin_o(cko), .subosc_drive_level_o(drv));
  task automatic give_verdict;
    $display("mismatches %0d, checks %0d", miscompares, tests_run);
    if (miscompares == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic fail(input string m);
    miscompares++;
    $display("mismatch at %0t: %s", $time, m);
    give_verdict();
  endtask
  // ack and read data are taken as sampled at the ack edge, then the request is dropped
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    req <= 1'b1;
    we <= w;
    adr <= a;
    dw <= d;
    do begin
      @(posedge clk_i);
      n++;
      if (n > 50) fail("no bus answer");
    end while (ack !== 1'b1);
    rv = dr;
    req <= 1'b0;
    we <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rv, e);
  endtask
  task automatic settle;
    repeat (2) @(posedge clk_i);
    #1;
  endtask
  task automatic wait_sig(input bit s, input logic v);
    int n;
    n = 0;
    do begin
      @(posedge clk_i);
      #1;
      n++;
      if (n > 9000) fail("signal never came");
    end while ((s ? cko : irq) !== v);
  endtask
  // polls a counter register until it moves; leaves almost a full second of quiet
  task automatic wait_step(input logic [7:0] a);
    logic [31:0] b;
    int n;
    bus(1'b0, a, 32'h0);
    b = rv;
    n = 0;
    do begin
      bus(1'b0, a, 32'h0);
      n++;
      if (n > 2000) fail("count stuck");
    end while (rv === b);
  endtask
  // a clear may lose to a simultaneous set, so retry until the line really drops
  task automatic next_rise;
    do begin
      wr(8'h0C, 32'h2);
      settle();
    end while (irq !== 1'b0);
    wait_sig(1'b0, 1'b1);
  endtask
  task automatic capture(input int n);
    @(posedge clk_i);
    evt <= 3'(1 << n);
    @(posedge clk_i);
    evt <= 3'h0;
    repeat (2) @(posedge clk_i);
  endtask
  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    chk(32'({irq, wake, cko, drv}), 32'h0);
    wr(8'hFC, 32'hFF);
    for (int a = 0; a < 8'h80; a += 4) begin
      if (a != 8'h14) rd(8'(a), 32'h0);
    end
    rd(8'hFC, 32'h0);
    wr(8'h08, 32'h5);
    rd(8'h08, 32'h5);
    chk(32'(drv), 32'h5);
    wr(8'h04, 32'h1);
    wait_step(8'h20);
    wr(8'h2C, 32'h0);
    for (int i = 0; i < 3; i++) wr(8'(8'h20 + 4 * i), 32'hFF);
    wait_step(8'h20);
    for (int i = 0; i < 4; i++) rd(8'(8'h20 + 4 * i), 32'(i == 3));
    wr(8'h30, 32'h2);
    wr(8'h40, 32'hFF);
    wr(8'h3C, 32'hFF);
    wr(8'h4C, 32'h1);
    wr(8'h0C, 32'h1F);
    k = 0;
    do begin
      bus(1'b0, 8'h0C, 32'h0);
      k++;
      if (k > 3000) fail("no alarm");
    end while (rv[0] !== 1'b1);
    rd(8'h20, 32'h2);
    chk(32'(irq), 32'h0);
    wr(8'h10, 32'h1);
    settle();
    chk(32'({irq, wake}), 32'h3);
    wr(8'h0C, 32'h1);
    settle();
    chk(32'(irq), 32'h0);
    wr(8'h10, 32'h2);
    for (int c = 6; c < 16; c++) begin
      wr(8'h00, 32'(c << 4));
      next_rise();
      t1 = $time;
      chk(32'(wake), 32'h1);
      next_rise();
      chk(32'(($time - t1) / 50), 32'((1 << (c - 6)) * TD));
    end
    for (int s = 0; s < 2; s++) begin
      wr(8'h00, 32'(s));
      wait_sig(1'b1, 1'b1);
      wait_sig(1'b1, 1'b0);
      t1 = $time;
      wait_sig(1'b1, 1'b1);
      chk(32'(($time - t1) / 50), 32'((s != 0 ? 32'h2 : 32'h80) * TD));
    end
    wait_step(8'h20);
    for (int i = 0; i < 4; i++) begin
      bus(1'b0, 8'(8'h20 + 4 * i), 32'h0);
      cnt[8 * i +: 8] = rv[7:0];
    end
    for (int n = 0; n < 3; n++) begin
      capture(n);
      for (int i = 0; i < 4; i++) rd(8'(8'h50 + 16 * n + 4 * i), 32'(cnt[8 * i +: 8]));
      bus(1'b0, 8'h0C, 32'h0);
      chk(32'(rv[2 + n]), 32'h1);
    end
    wait_step(8'h20);
    capture(1);
    rd(8'h50, 32'(cnt[7:0]));
    wr(8'h04, 32'h0);
    wait_step(8'h14);
    cnt = rv;
    for (int n = 0; n < 3; n += 2) begin
      capture(n);
      for (int i = 0; i < 4; i++) rd(8'(8'h50 + 16 * n + 4 * i), 32'(cnt[8 * i +: 8]));
    end
    give_verdict();
  end
endmodule // rbc_rtc_tb
